// [inc/ufs_defines.vh]
// Function
// - write index with bit7 set, then data
// - read index with bit7 clear, then data
// - one async write command opens buffer
// - writing bit2 clears end-of-transfer flag
// - async irq only when running and processed
// - async done only after running-state processing
// - max-packet fields set packet start cutoff before frame end
// - operational registers are 32 bits wide; code: only control, frame interval, ls threshold, rest 16
// - mixed frame raises two separate interrupts
// - iso irq flag set two cycles after frame start
// - async irq follows iso irq, cpu clears
// - active cleared on completion or fatal error
// - rewalk still-active descriptors while time remains
// - iso write completion sets half full
// - processed half gets its done bit
// - no iso write into full half
// - frame start swaps halves, sets processed half done
// - word read from done half clears both
// - unread done bits clear, iso halts
// - async write busy at frame start defers
// - iso write busy at frame start, no async irq
// - each port access moves two bytes
// - pointer reaching counter flags end of transfer; the code sets the flag on buffer writes only, not on reads
// - swap halves at frame start; both full selects half 1
`ifndef UFS_DEFINES_VH
`define UFS_DEFINES_VH
// ********************************
// register indexes
// ********************************
`define UFS_IDX_CONTROL 7'h01
`define UFS_IDX_FRAME_INTERVAL 7'h0d
`define UFS_IDX_LS_THRESHOLD 7'h11
`define UFS_IDX_XFER_COUNTER 7'h22
`define UFS_IDX_IRQ_FLAGS 7'h24
`define UFS_IDX_ISO_LEN 7'h2a
`define UFS_IDX_ASYNC_LEN 7'h2b
`define UFS_IDX_BUF_STATE 7'h2c
`define UFS_IDX_ISO_PORT 7'h40
`define UFS_IDX_ASYNC_PORT 7'h41
// ********************************
// command port encodings
// ********************************
`define UFS_CMD_WRITE_BIT 7
`define UFS_IDX_MASK 7'h7f
`define UFS_CMD_ASYNC_WR 8'hc1
`define UFS_CMD_ISO_WR 8'hc0
// ********************************
// field positions
// ********************************
`define UFS_IRQ_ISO 0
`define UFS_IRQ_ASYNC 1
`define UFS_IRQ_EOT 2
`define UFS_FS_MAX_HI 30
`define UFS_FS_MAX_LO 16
`define UFS_LS_THR_HI 11
`define UFS_RUN_HI 7
`define UFS_RUN_LO 6
`define UFS_RUN_CODE 2'h2
`define UFS_DESC_ACTIVE 15
`define UFS_DESC_LOW_SPEED 14
`define UFS_DESC_CNT_HI 9
`define UFS_DESC_HDR_WORDS 12'h004
`define UFS_PKT_BYTES 10'h040
// ********************************
// timing
// ********************************
`define UFS_FRAME_NS 1000000
`define UFS_CLK_NS 10
`endif

// [core/ufs_iso_pingpong.v]
`timescale 1ns/1ps
`include "ufs_defines.vh"
// ********************************
// ping/pong half status keeper
// ********************************
module ufs_iso_pingpong (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	// events
	input wire i_sof,
	input wire i_wr_eot,
	input wire i_rd_word,
	// status
	output wire o_cpu_half,
	output wire o_rd_half,
	output wire o_wr_ok,
	output wire [1:0] o_full,
	output wire [1:0] o_done,
	output wire o_halted,
	output wire o_iso_irq_set
);
	reg [1:0] full_q, full_d; // per-half full bits
	reg [1:0] done_q, done_d; // per-half done bits
	reg cpu_q, cpu_d; // half the processor writes
	reg halt_q, halt_d; // stuck until reset
	reg irq_q; // one-cycle iso irq pulse
	wire rd_half; // half a read clears
	assign rd_half = done_q[0] ? 1'b0 : (done_q[1] ? 1'b1 : cpu_q);
	assign o_cpu_half = cpu_q;
	assign o_rd_half = rd_half;
	assign o_wr_ok = ~full_q[cpu_q] & ~halt_q;
	assign o_full = full_q;
	assign o_done = done_q;
	assign o_halted = halt_q;
	assign o_iso_irq_set = irq_q;
	// next-state of the half bits
	always @* begin
		full_d = full_q;
		done_d = done_q;
		cpu_d = cpu_q;
		halt_d = halt_q;
		if (i_rd_word && done_q[rd_half]) begin
			full_d[rd_half] = 1'b0;
			done_d[rd_half] = 1'b0;
		end
		if (i_sof && !halt_q) begin
			if (done_q != 2'h0) begin
				// driver missed its frame: drop status and stop for good
				full_d = full_q & ~done_q;
				done_d = 2'h0;
				halt_d = 1'b1;
			end else begin
				if (full_q[~cpu_q])
					done_d[~cpu_q] = 1'b1;
				if (full_d[0] && full_d[1])
					cpu_d = 1'b1;
				else
					cpu_d = ~cpu_q;
			end
		end
		if (i_wr_eot)
			full_d[cpu_q] = 1'b1;
	end
	// state registers
	always @(posedge i_clk_sys) begin
		if (i_rst) begin
			full_q <= 2'h0;
			done_q <= 2'h0;
			cpu_q <= 1'b0;
			halt_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			full_q <= full_d;
			done_q <= done_d;
			cpu_q <= cpu_d;
			halt_q <= halt_d;
			irq_q <= i_sof & ~halt_q;
		end
	end
endmodule // ufs_iso_pingpong

// [core/ufs_frame_sched.v]
`timescale 1ns/1ps
`include "ufs_defines.vh"
// ********************************
// frame buffer scheduler top
// ********************************
module ufs_frame_sched #(
	parameter P_FRAME_CYCLES = `UFS_FRAME_NS / `UFS_CLK_NS
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_soft_rst,
	// command/data port
	input wire i_cmd_we,
	input wire [7:0] i_cmd,
	input wire i_dat_we,
	input wire [15:0] i_dat,
	input wire i_dat_re,
	output wire [15:0] o_dat,
	// usb engine
	output wire o_usb_start,
	output wire [9:0] o_usb_len,
	output wire o_usb_low_speed,
	input wire i_usb_done,
	input wire i_usb_fatal,
	// status
	output wire o_sof,
	output wire o_iso_active
);
	// ********************************
	// declarations
	// ********************************
	localparam S_IDLE = 5'h01; // no walk
	localparam S_HDR = 5'h02; // fetch header word
	localparam S_LEN = 5'h04; // fetch length, decide
	localparam S_XFER = 5'h08; // packet on the bus
	localparam S_NEXT = 5'h10; // step to next descriptor
	wire rst; // combined reset
	reg [15:0] ram [0:2047]; // shared buffer memory, 16-bit words
	reg [7:0] cmd_q; // last command code
	reg hi_q; // high half of a 32-bit register next
	reg [11:0] ptr_q; // byte pointer of buffer port
	reg [31:0] control_q; // run state lives in bits 7:6
	reg [31:0] fm_interval_q;
	reg [31:0] ls_thr_q;
	reg [15:0] xfer_cnt_q;
	reg [15:0] iso_len_q;
	reg [15:0] async_len_q;
	reg [2:0] irq_q; // iso, async, end of transfer
	reg async_full_q, async_done_q;
	reg async_open_q, iso_open_q; // buffer write in progress
	reg [15:0] dat_q; // read data register
	reg ld_q; // a port strobe last cycle: reload read data
	reg [16:0] frame_cnt_q; // cycles into frame
	reg sof_q;
	reg no_async_irq_q; // suppress async irq this frame
	reg [4:0] st_q;
	reg [11:0] sch_ptr_q; // descriptor word index
	reg [15:0] hdr_q; // header of current descriptor
	reg [9:0] len_q; // packet length in flight
	reg any_act_q; // some descriptor still active this pass
	reg done_seen_q, fatal_seen_q; // latched engine answers
	reg start_q;
	wire [6:0] idx;
	wire running;
	wire [16:0] remain;
	wire time_ok;
	wire [11:0] iso_half_words;
	wire [10:0] port_word;
	wire [11:0] ptr_inc;
	wire transfer_end;
	wire cpu_half, rd_half, wr_ok, halted, iso_irq_set;
	wire [1:0] full, done;
	wire async_wr, iso_wr, buf_rd, buf_wr, port_sel;
	wire [11:0] async_words;
	wire [11:0] stride;
	wire [9:0] rem_bytes;
	wire wb_free;
	assign rst = i_rst | i_soft_rst;
	assign idx = cmd_q[6:0] & `UFS_IDX_MASK;
	assign running = (control_q[`UFS_RUN_HI:`UFS_RUN_LO] == `UFS_RUN_CODE);
	assign remain = P_FRAME_CYCLES[16:0] - frame_cnt_q;
	assign iso_half_words = {1'b0, iso_len_q[11:1]};
	assign async_words = {1'b0, async_len_q[11:1]};
	assign ptr_inc = ptr_q + 12'h002;
	assign transfer_end = ({4'h0, ptr_inc} >= xfer_cnt_q);
	assign async_wr = i_dat_we && (cmd_q == `UFS_CMD_ASYNC_WR);
	assign iso_wr = i_dat_we && (cmd_q == `UFS_CMD_ISO_WR) && wr_ok;
	assign buf_wr = async_wr | iso_wr;
	assign port_sel = (idx == `UFS_IDX_ISO_PORT) || (idx == `UFS_IDX_ASYNC_PORT);
	assign buf_rd = i_dat_re && port_sel && !cmd_q[`UFS_CMD_WRITE_BIT];
	assign wb_free = ~i_dat_we; // cpu writes own the memory port first
	assign rem_bytes = hdr_q[`UFS_DESC_CNT_HI:0];
	// ********************************
	// functions
	// ********************************
	// byte count rounded to whole dwords, in words
	function [11:0] pad_words;
		input [9:0] bytes;
		begin
			pad_words = (({2'h0, bytes} + 12'h003) >> 2) << 1;
		end
	endfunction
	// word address for a port at a byte pointer
	function [10:0] port_addr;
		input iso;
		input half;
		input [11:0] bptr;
		input [11:0] aw;
		input [11:0] hw;
		reg [11:0] base;
		begin
			base = iso ? (aw + (half ? hw : 12'h000)) : 12'h000;
			port_addr = base[10:0] + bptr[11:1];
		end
	endfunction
	// register read mux
	function [15:0] reg_rd;
		input [6:0] i;
		input h;
		begin
			case (i)
				`UFS_IDX_CONTROL: reg_rd = h ? control_q[31:16] : control_q[15:0];
				`UFS_IDX_FRAME_INTERVAL: reg_rd = h ? fm_interval_q[31:16] : fm_interval_q[15:0];
				`UFS_IDX_LS_THRESHOLD: reg_rd = h ? ls_thr_q[31:16] : ls_thr_q[15:0];
				`UFS_IDX_XFER_COUNTER: reg_rd = xfer_cnt_q;
				`UFS_IDX_IRQ_FLAGS: reg_rd = {13'h0000, irq_q};
				`UFS_IDX_ISO_LEN: reg_rd = iso_len_q;
				`UFS_IDX_ASYNC_LEN: reg_rd = async_len_q;
				`UFS_IDX_BUF_STATE: reg_rd = {10'h000, async_done_q, done, async_full_q, full};
				default: reg_rd = 16'h0000;
			endcase
		end
	endfunction
	// is this a 32-bit register taking two port cycles
	function is_wide;
		input [6:0] i;
		begin
			is_wide = (i == `UFS_IDX_CONTROL) || (i == `UFS_IDX_FRAME_INTERVAL)
				|| (i == `UFS_IDX_LS_THRESHOLD);
		end
	endfunction
	// writes go to the cpu half, reads to the half waiting to be read
	assign port_word = port_addr(cmd_q[0] == 1'b0,
		cmd_q[`UFS_CMD_WRITE_BIT] ? cpu_half : rd_half, ptr_q, async_words, iso_half_words);
	assign stride = `UFS_DESC_HDR_WORDS + pad_words(ram[sch_ptr_q[10:0] + 11'h001][9:0]);
	// a packet may start only while the frame has room for the largest one
	assign time_ok = hdr_q[`UFS_DESC_LOW_SPEED] ?
		(remain > {5'h00, ls_thr_q[`UFS_LS_THR_HI:0]}) :
		(remain > {2'h0, fm_interval_q[`UFS_FS_MAX_HI:`UFS_FS_MAX_LO]});
	// ********************************
	// iso half status
	// ********************************
	ufs_iso_pingpong u_iso (
		.i_clk_sys(i_clk_sys),
		.i_rst(rst),
		.i_sof(sof_q),
		.i_wr_eot(iso_wr && transfer_end),
		.i_rd_word(buf_rd && (idx == `UFS_IDX_ISO_PORT)),
		.o_cpu_half(cpu_half),
		.o_rd_half(rd_half),
		.o_wr_ok(wr_ok),
		.o_full(full),
		.o_done(done),
		.o_halted(halted),
		.o_iso_irq_set(iso_irq_set)
	);
	// ********************************
	// frame timer
	// ********************************
	// free-running 1 ms frame, start-of-frame pulse at wrap
	always @(posedge i_clk_sys) begin
		if (rst) begin
			frame_cnt_q <= 17'h00000;
			sof_q <= 1'b0;
		end else if (frame_cnt_q == P_FRAME_CYCLES[16:0] - 17'h00001) begin
			frame_cnt_q <= 17'h00000;
			sof_q <= 1'b1;
		end else begin
			frame_cnt_q <= frame_cnt_q + 17'h00001;
			sof_q <= 1'b0;
		end
	end
	// ********************************
	// command and data port
	// ********************************
	always @(posedge i_clk_sys) begin
		if (rst) begin
			cmd_q <= 8'h00;
			hi_q <= 1'b0;
			ptr_q <= 12'h000;
			control_q <= 32'h00000000;
			fm_interval_q <= 32'h00000000;
			ls_thr_q <= 32'h00000000;
			xfer_cnt_q <= 16'h0000;
			iso_len_q <= 16'h0000;
			async_len_q <= 16'h0000;
			async_open_q <= 1'b0;
			iso_open_q <= 1'b0;
			dat_q <= 16'h0000;
			ld_q <= 1'b0;
		end else begin
			// reload only after a strobe, so the word stands between accesses
			ld_q <= i_cmd_we | i_dat_we | i_dat_re;
			if (ld_q)
				dat_q <= port_sel ? ram[port_word] : reg_rd(idx, hi_q);
			if (i_cmd_we) begin
				// a new command restarts word pairing and the buffer pointer
				cmd_q <= i_cmd;
				hi_q <= 1'b0;
				ptr_q <= 12'h000;
				async_open_q <= (i_cmd == `UFS_CMD_ASYNC_WR);
				iso_open_q <= (i_cmd == `UFS_CMD_ISO_WR);
			end else if (buf_wr || buf_rd) begin
				ptr_q <= ptr_inc;
				if (transfer_end) begin
					async_open_q <= 1'b0;
					iso_open_q <= 1'b0;
				end
			end else if (i_dat_we && cmd_q[`UFS_CMD_WRITE_BIT]) begin
				// register write, low half first for 32-bit registers
				hi_q <= is_wide(idx) & ~hi_q;
				case (idx)
					`UFS_IDX_CONTROL:
						if (hi_q) control_q[31:16] <= i_dat;
						else control_q[15:0] <= i_dat;
					`UFS_IDX_FRAME_INTERVAL:
						if (hi_q) fm_interval_q[31:16] <= i_dat;
						else fm_interval_q[15:0] <= i_dat;
					`UFS_IDX_LS_THRESHOLD:
						if (hi_q) ls_thr_q[31:16] <= i_dat;
						else ls_thr_q[15:0] <= i_dat;
					`UFS_IDX_XFER_COUNTER: xfer_cnt_q <= i_dat;
					`UFS_IDX_ISO_LEN: iso_len_q <= i_dat;
					`UFS_IDX_ASYNC_LEN: async_len_q <= i_dat;
					default: hi_q <= 1'b0; // read-only or unmapped: ignored
				endcase
			end else if (i_dat_re && is_wide(idx)) begin
				hi_q <= ~hi_q;
			end
		end
	end
	// ********************************
	// buffer memory write port
	// ********************************
	// low byte even address, high byte odd, one word per access
	always @(posedge i_clk_sys) begin
		if (buf_wr)
			ram[port_word] <= i_dat;
		else if (st_q == S_XFER && (done_seen_q || fatal_seen_q))
			ram[sch_ptr_q[10:0]] <= {hdr_q[15] & ~fatal_seen_q & (rem_bytes != len_q),
				hdr_q[14:10], rem_bytes - len_q};
	end
	// ********************************
	// interrupt and async status flags
	// ********************************
	// hardware set wins over a same-cycle software clear
	always @(posedge i_clk_sys) begin
		if (rst) begin
			irq_q <= 3'h0;
			async_full_q <= 1'b0;
			async_done_q <= 1'b0;
		end else begin
			if (i_dat_we && cmd_q[`UFS_CMD_WRITE_BIT] && idx == `UFS_IDX_IRQ_FLAGS)
				irq_q <= irq_q & ~i_dat[2:0];
			if (iso_irq_set)
				irq_q[`UFS_IRQ_ISO] <= 1'b1;
			if (st_q == S_HDR && sch_ptr_q >= async_words && !(any_act_q && time_ok)
				&& !no_async_irq_q)
				irq_q[`UFS_IRQ_ASYNC] <= 1'b1;
			if (buf_wr && transfer_end)
				irq_q[`UFS_IRQ_EOT] <= 1'b1;
			if (i_cmd_we && i_cmd == `UFS_CMD_ASYNC_WR) begin
				async_full_q <= 1'b0;
				async_done_q <= 1'b0;
			end
			if (async_wr && transfer_end)
				async_full_q <= 1'b1;
			if (st_q == S_HDR && sch_ptr_q >= async_words && !(any_act_q && time_ok))
				async_done_q <= 1'b1;
		end
	end
	// ********************************
	// async descriptor walk
	// ********************************
	always @(posedge i_clk_sys) begin
		if (rst) begin
			st_q <= S_IDLE;
			sch_ptr_q <= 12'h000;
			hdr_q <= 16'h0000;
			len_q <= 10'h000;
			any_act_q <= 1'b0;
			done_seen_q <= 1'b0;
			fatal_seen_q <= 1'b0;
			start_q <= 1'b0;
			no_async_irq_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (i_usb_done)
				done_seen_q <= 1'b1;
			if (i_usb_fatal)
				fatal_seen_q <= 1'b1;
			if (sof_q)
				no_async_irq_q <= iso_open_q;
			case (st_q)
				S_IDLE: begin
					// start only with a full list, running, and the cpu done writing
					if (sof_q && running && async_full_q && !async_done_q && !async_open_q
						&& !iso_open_q) begin
						st_q <= S_HDR;
						sch_ptr_q <= 12'h000;
						any_act_q <= 1'b0;
					end
				end
				S_HDR: begin
					if (sch_ptr_q >= async_words) begin
						if (any_act_q && time_ok) begin
							sch_ptr_q <= 12'h000;
							any_act_q <= 1'b0;
						end else begin
							st_q <= S_IDLE;
						end
					end else begin
						// past the list end the memory holds no header
						hdr_q <= ram[sch_ptr_q[10:0]];
						st_q <= S_LEN;
					end
				end
				S_LEN: begin
					if (hdr_q[`UFS_DESC_ACTIVE] && time_ok) begin
						len_q <= (rem_bytes > `UFS_PKT_BYTES) ? `UFS_PKT_BYTES : rem_bytes;
						start_q <= 1'b1;
						done_seen_q <= 1'b0;
						fatal_seen_q <= 1'b0;
						st_q <= S_XFER;
					end else begin
						any_act_q <= any_act_q | hdr_q[`UFS_DESC_ACTIVE];
						st_q <= S_NEXT;
					end
				end
				S_XFER: begin
					// write-back waits while the cpu holds the memory port
					if ((done_seen_q || fatal_seen_q) && wb_free) begin
						any_act_q <= any_act_q | (~fatal_seen_q & (rem_bytes != len_q));
						st_q <= S_NEXT;
					end
				end
				S_NEXT: begin
					sch_ptr_q <= sch_ptr_q + stride;
					st_q <= S_HDR;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
	// ********************************
	// outputs
	// ********************************
	assign o_dat = dat_q;
	assign o_usb_start = start_q;
	assign o_usb_len = len_q;
	assign o_usb_low_speed = hdr_q[`UFS_DESC_LOW_SPEED];
	assign o_sof = sof_q;
	assign o_iso_active = running & ~halted & full[~cpu_half] & ~done[~cpu_half];
endmodule // ufs_frame_sched

// [tb/ufs_frame_sched_monitor.sv]
`timescale 1ns/1ps
// ****
// port checker for the frame scheduler
// ****
module ufs_frame_sched_monitor #(
	parameter P_FRAME_CYCLES = 100000
) (
	// clock and reset
	input wire i_clk_sys,
	input wire i_rst,
	input wire i_soft_rst,
	// command/data port
	input wire i_cmd_we,
	input wire [7:0] i_cmd,
	input wire i_dat_we,
	input wire [15:0] i_dat,
	input wire i_dat_re,
	input wire [15:0] o_dat,
	// usb engine
	input wire o_usb_start,
	input wire [9:0] o_usb_len,
	input wire o_usb_low_speed,
	input wire i_usb_done,
	input wire i_usb_fatal,
	// status
	input wire o_sof,
	input wire o_iso_active
);
	wire rst = i_rst | i_soft_rst; // both resets act alike
	reg [31:0] cyc_q; // cycles since frame start
	reg seen_q; // frame start seen since reset
	reg busy_q; // packet out, no answer yet
	reg fi_sel_q; // frame interval index latched
	reg fi_hi_q; // next word is the high half
	reg [14:0] fs_q; // copy of full speed cutoff
	// ****
	// helper state
	// ****
	// snooping the port keeps the checker free of design internals
	always @(posedge i_clk_sys) begin
		if (rst) begin
			cyc_q <= 32'h0;
			seen_q <= 1'b0;
			busy_q <= 1'b0;
			fi_sel_q <= 1'b0;
			fi_hi_q <= 1'b0;
			fs_q <= 15'h0;
		end else begin
			cyc_q <= o_sof ? 32'h1 : cyc_q + 32'h1;
			seen_q <= seen_q | o_sof;
			busy_q <= o_usb_start | (busy_q & ~i_usb_done & ~i_usb_fatal);
			if (i_cmd_we) begin
				fi_sel_q <= (i_cmd == 8'h8d);
				fi_hi_q <= 1'b0;
			end else if (i_dat_we && fi_sel_q) begin
				fi_hi_q <= ~fi_hi_q;
				if (fi_hi_q)
					fs_q <= i_dat[14:0];
			end
		end
	end
	// ****
	// assertions
	// ****
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (rst);
	a_sof_single: assert property (o_sof |=> !o_sof [*8])
		else $error("frame start pulse too long");
	a_sof_period: assert property (o_sof && seen_q |-> cyc_q == P_FRAME_CYCLES)
		else $error("frame start spacing wrong");
	a_len_range: assert property (o_usb_start |-> o_usb_len != 10'h0 && o_usb_len <= 10'h40)
		else $error("packet length out of range");
	a_one_packet: assert property (o_usb_start |-> !busy_q)
		else $error("packet started before answer");
	a_fs_cutoff: assert property (
		o_usb_start && !o_usb_low_speed |-> P_FRAME_CYCLES + 2 > cyc_q + fs_q)
		else $error("packet started past cutoff");
	a_walk_after_sof: assert property (o_usb_start |-> seen_q)
		else $error("packet before any frame start");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |=> o_dat == 16'h0 && !o_sof && !o_usb_start && !o_iso_active)
		else $error("outputs not cleared by reset");
	a_dat_stands: assert property (
		!i_cmd_we && !i_dat_we && !i_dat_re && !$past(i_cmd_we) && !$past(i_dat_we)
		&& !$past(i_dat_re) |=> $stable(o_dat))
		else $error("read data moved without strobe");
endmodule // ufs_frame_sched_monitor

bind ufs_frame_sched ufs_frame_sched_monitor #(.P_FRAME_CYCLES(P_FRAME_CYCLES)) mon_u (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_soft_rst(i_soft_rst),
	.i_cmd_we(i_cmd_we), .i_cmd(i_cmd), .i_dat_we(i_dat_we), .i_dat(i_dat),
	.i_dat_re(i_dat_re), .o_dat(o_dat), .o_usb_start(o_usb_start),
	.o_usb_len(o_usb_len), .o_usb_low_speed(o_usb_low_speed),
	.i_usb_done(i_usb_done), .i_usb_fatal(i_usb_fatal), .o_sof(o_sof),
	.o_iso_active(o_iso_active)
);

// [tb/ufs_usb_model.sv]
`timescale 1ns/1ps
// ****
// usb engine stand-in
// ****
module ufs_usb_model (
	// clock
	input wire i_clk_sys,
	// engine side
	input wire i_start,
	input wire i_low_speed,
	input wire i_fail_ls,
	output reg o_done,
	output reg o_fatal
);
	reg slow = 1'b0; // alternates prompt and slow answers
	reg bad; // this packet ends in a fatal error
	// one packet at a time, answer after a delay
	initial begin
		o_done = 1'b0;
		o_fatal = 1'b0;
		forever begin
			@(posedge i_clk_sys);
			if (i_start === 1'b1) begin
				bad = i_fail_ls & i_low_speed; // only when commanded
				slow = ~slow;
				repeat (slow ? 40 : 1) @(posedge i_clk_sys);
				#1;
				o_done = ~bad;
				o_fatal = bad;
				@(posedge i_clk_sys);
				#1;
				o_done = 1'b0;
				o_fatal = 1'b0;
			end
		end
	end
endmodule // ufs_usb_model

// [tb/ufs_frame_sched_test.sv]
`timescale 1ns/1ps
// ****
// frame scheduler bench
// ****
module ufs_frame_sched_test;
	localparam P_FC = 2000; // short frame keeps the run small
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg srst = 1'b0;
	reg cmd_we = 1'b0;
	reg [7:0] cmd_v = 8'h00;
	reg dat_we = 1'b0;
	reg [15:0] dat_v = 16'h0000;
	reg dat_re = 1'b0;
	reg fail_ls = 1'b0; // partner fails low speed packets
	reg take = 1'b0; // read result due at next edge
	wire [15:0] o_dat;
	wire start, ls, done, fatal, sof, iso_act;
	wire [9:0] len;
	integer seed = 19;
	integer miscompares = 0;
	integer check_count = 0;
	integer w;
	reg [15:0] rv; // random word
	reg [15:0] eq[$]; // expected read data
	reg [15:0] mq[$]; // mask of bits that matter
	reg [10:0] lq[$]; // expected {low speed, length}
	ufs_frame_sched #(.P_FRAME_CYCLES(P_FC)) dut_u (
		.i_clk_sys(clk), .i_rst(rst), .i_soft_rst(srst),
		.i_cmd_we(cmd_we), .i_cmd(cmd_v), .i_dat_we(dat_we), .i_dat(dat_v),
		.i_dat_re(dat_re), .o_dat(o_dat), .o_usb_start(start), .o_usb_len(len),
		.o_usb_low_speed(ls), .i_usb_done(done), .i_usb_fatal(fatal),
		.o_sof(sof), .o_iso_active(iso_act)
	);
	ufs_usb_model usb_u (.i_clk_sys(clk), .i_start(start), .i_low_speed(ls),
		.i_fail_ls(fail_ls), .o_done(done), .o_fatal(fatal));
	initial begin
		forever #5 clk = ~clk;
	end
	// ****
	// port tasks
	// ****
	// every strobe is followed by an idle edge, so no signal flips twice at once
	task tick;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task wc(input [7:0] c);
		begin
			cmd_we = 1'b1;
			cmd_v = c;
			tick;
			cmd_we = 1'b0;
			tick;
		end
	endtask
	task wd(input [15:0] d);
		begin
			dat_we = 1'b1;
			dat_v = d;
			tick;
			dat_we = 1'b0;
			tick;
		end
	endtask
	task rd;
		begin
			dat_re = 1'b1;
			tick;
			dat_re = 1'b0;
			tick;
		end
	endtask
	task note(input [15:0] e, input [15:0] m);
		begin
			eq.push_back(e);
			mq.push_back(m);
			take = 1'b1;
			tick;
			take = 1'b0;
			tick;
		end
	endtask
	task wreg(input [6:0] i, input [15:0] d);
		begin
			wc({1'b1, i});
			wd(d);
		end
	endtask
	task rreg(input [6:0] i, input [15:0] e, input [15:0] m);
		begin
			wc({1'b0, i});
			note(e, m);
		end
	endtask
	task iwr; // four iso words, never an active descriptor
		integer k;
		begin
			wc(8'hc0);
			for (k = 0; k < 4; k = k + 1) begin
				rv = $random(seed);
				wd(rv & 16'h3fff);
			end
		end
	endtask
	task sofw; // bounded wait past the next frame start
		integer k;
		begin
			k = 0;
			while (sof !== 1'b1 && k < 3000) begin
				tick;
				k = k + 1;
			end
			tick;
		end
	endtask
	task pgm; // running state, 8-byte iso halves
		begin
			srst = 1'b1;
			tick;
			srst = 1'b0;
			tick;
			wc(8'h81);
			wd(16'h0080);
			wd(16'h0000);
			wreg(7'h2a, 16'h0008);
			wreg(7'h22, 16'h0008);
		end
	endtask
	// ****
	// result watcher
	// ****
	task cmp_dat(input [15:0] g);
		reg [15:0] e;
		reg [15:0] m;
		begin
			e = eq.pop_front();
			m = mq.pop_front();
			check_count = check_count + 1;
			if ((g & m) !== (e & m)) begin
				miscompares = miscompares + 1;
				$display("Error %0t got %h exp %h", $time, g & m, e & m);
			end
		end
	endtask
	task cmp_len(input [10:0] g);
		reg [10:0] e;
		begin
			e = (lq.size() != 0) ? lq.pop_front() : 11'h7ff;
			check_count = check_count + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("Error %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	always @(posedge clk) begin
		if (take)
			cmp_dat(o_dat);
		if (start === 1'b1)
			cmp_len({ls, len});
	end
	task complete_run;
		begin
			$display("checks %0d miscompares %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// ****
	// scenarios
	// ****
	initial begin
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		rreg(7'h2c, 16'h0000, 16'h003f);
		rv = $random(seed);
		wreg(7'h22, rv);
		rreg(7'h22, rv, 16'hffff);
		wreg(7'h2c, 16'h003f);
		rreg(7'h2c, 16'h0000, 16'h003f);
		rreg(7'h30, 16'h0000, 16'hffff);
		wc(8'h8d);
		wd(16'h1234);
		wd(16'h0010);
		rreg(7'h0d, 16'h1234, 16'hffff);
		rd;
		note(16'h0010, 16'h7fff);
		wc(8'h91);
		wd(16'h0020);
		wd(16'h0000);
		// async load while idle: end of transfer only
		wreg(7'h24, 16'h0007);
		wreg(7'h2b, 16'h0050);
		wreg(7'h22, 16'h0050);
		wc(8'hc1);
		for (w = 0; w < 40; w = w + 1)
			wd({w[6:0], 1'b1, w[6:0], 1'b0});
		rreg(7'h24, 16'h0004, 16'h0006);
		rreg(7'h2c, 16'h0004, 16'h0024);
		wreg(7'h24, 16'h0004);
		rreg(7'h24, 16'h0000, 16'h0004);
		wc(8'h41);
		note(16'h0100, 16'hffff);
		rd;
		note(16'h0302, 16'hffff);
		// running: two descriptors, low speed one fails, first is rewalked
		sofw; // a whole frame ahead, so the stale list is never walked
		wc(8'h81);
		wd(16'h0080);
		wd(16'h0000);
		wreg(7'h24, 16'h0007);
		wreg(7'h2b, 16'h00c4);
		wreg(7'h22, 16'h00c4);
		fail_ls = 1'b1;
		lq.push_back(11'h040);
		lq.push_back(11'h440);
		lq.push_back(11'h024);
		wc(8'hc1);
		for (w = 0; w < 98; w = w + 1) begin
			rv = $random(seed);
			wd(w == 0 ? 16'h8064 : w == 1 ? 16'h0064 : w == 54 ? 16'hc050 :
				w == 55 ? 16'h0050 : rv);
		end
		rreg(7'h24, 16'h0004, 16'h0004);
		w = 0;
		while (lq.size() != 0 && w < 6000) begin
			tick;
			w = w + 1;
		end
		repeat (60) tick;
		rreg(7'h24, 16'h0002, 16'h0002);
		rreg(7'h2c, 16'h0024, 16'h0024);
		// iso ping-pong from a known half
		pgm;
		iwr;
		rreg(7'h2c, 16'h0001, 16'h001b);
		wreg(7'h24, 16'h0004);
		iwr;
		rreg(7'h24, 16'h0000, 16'h0004);
		sofw;
		iwr;
		rreg(7'h2c, 16'h0003, 16'h001b);
		sofw;
		rreg(7'h2c, 16'h000b, 16'h001b);
		rreg(7'h24, 16'h0001, 16'h0001);
		wreg(7'h24, 16'h0001);
		wc(8'h40);
		rd;
		rreg(7'h2c, 16'h0002, 16'h001b);
		sofw;
		sofw;
		rreg(7'h2c, 16'h0012, 16'h001b);
		sofw;
		rreg(7'h2c, 16'h0000, 16'h001b);
		wreg(7'h24, 16'h0001);
		sofw;
		rreg(7'h24, 16'h0000, 16'h0001);
		iwr;
		rreg(7'h2c, 16'h0000, 16'h0003);
		pgm;
		iwr;
		rreg(7'h2c, 16'h0001, 16'h0003);
		cmp_len(11'h7ff);
		complete_run;
	end
	initial begin
		repeat (40000) @(posedge clk);
		miscompares = miscompares + 1;
		complete_run;
	end
endmodule // ufs_frame_sched_test
